// *** verilog/cfsd_consts.svh ***
// Reset values and pipeline figures for the configuration strap decoder
`ifndef CFSD_CONSTS_SVH
`define CFSD_CONSTS_SVH

// Reset value of a sampled strap or level input
`define CFSD_PIN_RST 1'b0
// Reset value of the sampled active-low chip select (idle high)
`define CFSD_CS_N_RST 1'b1
// Reset value of the host access qualifiers
`define CFSD_ACCESS_RST 1'b0
// Edges from a pin change to the decoded outputs
`define CFSD_LATENCY 2

`endif

// *** verilog/cfsd_pkg.sv ***
// Types shared by the configuration strap decoder modules
package cfsd_pkg;

    // Operating mode, one-hot
    typedef enum logic [2:0] {
        CFSD_MODE_HW  = 3'h1,
        CFSD_MODE_PAR = 3'h2,
        CFSD_MODE_SER = 3'h4
    } cfsd_mode_t;

    // Line coder selection, one-hot
    typedef enum logic [2:0] {
        CFSD_LC_AMI  = 3'h1,
        CFSD_LC_HDB3 = 3'h2,
        CFSD_LC_B8ZS = 3'h4
    } cfsd_code_t;

    // Jitter attenuator position, one-hot
    typedef enum logic [2:0] {
        CFSD_JIT_TX  = 3'h1,
        CFSD_JIT_RX  = 3'h2,
        CFSD_JIT_OFF = 3'h4
    } cfsd_jit_t;

    // Host bus convention, one-hot
    typedef enum logic [1:0] {
        CFSD_BUS_SPLIT = 2'h1,
        CFSD_BUS_DSRW  = 2'h2
    } cfsd_bus_t;

endpackage

// *** verilog/cfsd_mode_if.sv ***
// Carrier for the decoded operating mode between decoder and top
`timescale 1ns/100ps
interface cfsd_mode_if;
    import cfsd_pkg::*;
    cfsd_mode_t mode; // Registered operating mode
    logic hw;         // Hardware mode flag
    logic host;       // Either host processor mode

    modport src (output mode, output hw, output host);
    modport dst (input mode, input hw, input host);
endinterface

// *** verilog/cfsd_mode_dec.sv ***
// Operating-mode decoder for the three-level mode strap
`timescale 1ns/100ps
module cfsd_mode_dec
    import cfsd_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic op_mode_high,
    input wire logic op_mode_mid,
    cfsd_mode_if.src mif
);
    cfsd_mode_t mode_reg;  // Current mode
    cfsd_mode_t mode_next; // Next mode

    // Mid level wins: the pad flags mid even when the level reads high
    always_comb begin
        mode_next = CFSD_MODE_HW;
        if (op_mode_mid) begin
            mode_next = CFSD_MODE_SER;
        end else if (op_mode_high) begin
            mode_next = CFSD_MODE_PAR;
        end
    end

    // Reset lands in hardware mode, host port closed
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            mode_reg <= CFSD_MODE_HW;
        end else begin
            mode_reg <= mode_next;
        end
    end

    assign mif.mode = mode_reg;
    assign mif.hw = (mode_reg == CFSD_MODE_HW);
    assign mif.host = (mode_reg != CFSD_MODE_HW);
endmodule

// *** verilog/cfsd_top.sv ***
// Configuration and mode-select strap decoder, top level
`timescale 1ns/100ps
`include "cfsd_consts.svh"
module cfsd_top
    import cfsd_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic op_mode_high,
    input wire logic op_mode_mid,
    input wire logic code_style_pin,
    input wire logic cs_jitter_pin,
    input wire logic cs_jitter_float,
    input wire logic unipolar_mode,
    input wire logic e1_rate,
    input wire logic sw_line_code_bit,
    input wire cfsd_jit_t sw_jitter_pos,
    output cfsd_mode_t mode_out,
    output logic host_port_en,
    output cfsd_code_t line_code,
    output cfsd_bus_t bus_style,
    output cfsd_jit_t jitter_pos,
    output logic host_access_en,
    output logic host_access_start
);
    cfsd_mode_if mif(); // Decoded mode from the strap decoder

    // Sampled pins, aligned with the registered mode
    logic code_pin_reg, code_pin_next;
    logic cs_n_reg, cs_n_next;
    logic jit_float_reg, jit_float_next;
    logic unipolar_reg, unipolar_next;
    logic e1_reg, e1_next;
    logic sw_code_reg, sw_code_next;
    cfsd_jit_t sw_jit_reg, sw_jit_next;
    logic cs_prev_reg, cs_prev_next; // Chip select one sample earlier

    // Decoded outputs
    cfsd_mode_t mode_out_reg, mode_out_next;
    cfsd_code_t line_code_reg, line_code_next;
    cfsd_bus_t bus_style_reg, bus_style_next;
    cfsd_jit_t jitter_pos_reg, jitter_pos_next;
    logic access_en_reg, access_en_next;
    logic access_start_reg, access_start_next;

    // Shared by the pin path and the software path
    function automatic cfsd_code_t code_pick(input logic transparent, input logic e1);
        cfsd_code_t pick;
        pick = CFSD_LC_AMI;
        if (!transparent) begin
            pick = e1 ? CFSD_LC_HDB3 : CFSD_LC_B8ZS;
        end
        return pick;
    endfunction

    // Mode strap decoder
    cfsd_mode_dec u_mode (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .op_mode_high(op_mode_high),
        .op_mode_mid(op_mode_mid),
        .mif(mif.src)
    );

    // Input sampling stage; one edge, same as the mode decoder
    always_comb begin
        code_pin_next = code_style_pin;
        cs_n_next = cs_jitter_pin;
        jit_float_next = cs_jitter_float;
        unipolar_next = unipolar_mode;
        e1_next = e1_rate;
        sw_code_next = sw_line_code_bit;
        sw_jit_next = sw_jitter_pos;
        cs_prev_next = cs_n_reg;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            code_pin_reg <= `CFSD_PIN_RST;
            cs_n_reg <= `CFSD_CS_N_RST;
            jit_float_reg <= `CFSD_PIN_RST;
            unipolar_reg <= `CFSD_PIN_RST;
            e1_reg <= `CFSD_PIN_RST;
            sw_code_reg <= `CFSD_PIN_RST;
            sw_jit_reg <= CFSD_JIT_OFF;
            cs_prev_reg <= `CFSD_CS_N_RST;
        end else begin
            code_pin_reg <= code_pin_next;
            cs_n_reg <= cs_n_next;
            jit_float_reg <= jit_float_next;
            unipolar_reg <= unipolar_next;
            e1_reg <= e1_next;
            sw_code_reg <= sw_code_next;
            sw_jit_reg <= sw_jit_next;
            cs_prev_reg <= cs_prev_next;
        end
    end

    // Decode stage: each shared pin is read under one meaning only
    always_comb begin
        mode_out_next = mif.mode;
        line_code_next = CFSD_LC_AMI;
        bus_style_next = CFSD_BUS_SPLIT;
        // Host default: position from software, the pin means chip select
        jitter_pos_next = sw_jit_reg;
        access_en_next = `CFSD_ACCESS_RST;
        access_start_next = `CFSD_ACCESS_RST;
        case (mif.mode)
            CFSD_MODE_HW: begin
                // Host port closed; pins carry hardware meanings
                // Bipolar data bypasses the coder, so it stays transparent
                if (unipolar_reg) begin
                    line_code_next = code_pick(code_pin_reg, e1_reg);
                end
                // Floating pin has priority over its sampled level
                if (jit_float_reg) begin
                    jitter_pos_next = CFSD_JIT_OFF;
                end else if (cs_n_reg) begin
                    jitter_pos_next = CFSD_JIT_RX;
                end else begin
                    jitter_pos_next = CFSD_JIT_TX;
                end
            end
            CFSD_MODE_PAR, CFSD_MODE_SER: begin
                // Pin now means bus style; coder from software
                line_code_next = code_pick(sw_code_reg, e1_reg);
                bus_style_next = code_pin_reg ? CFSD_BUS_SPLIT : CFSD_BUS_DSRW;
                access_en_next = !cs_n_reg;
                // Only a fresh high-to-low edge opens an access
                access_start_next = cs_prev_reg && !cs_n_reg;
            end
            default: begin
                // Unreachable code: fall back to AMI with host access disabled
                line_code_next = CFSD_LC_AMI;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            mode_out_reg <= CFSD_MODE_HW;
            line_code_reg <= CFSD_LC_AMI;
            bus_style_reg <= CFSD_BUS_SPLIT;
            jitter_pos_reg <= CFSD_JIT_OFF;
            access_en_reg <= `CFSD_ACCESS_RST;
            access_start_reg <= `CFSD_ACCESS_RST;
        end else begin
            mode_out_reg <= mode_out_next;
            line_code_reg <= line_code_next;
            bus_style_reg <= bus_style_next;
            jitter_pos_reg <= jitter_pos_next;
            access_en_reg <= access_en_next;
            access_start_reg <= access_start_next;
        end
    end

    // Outputs straight from flip-flops, except host_port_en, which is decoded from mode_out_reg
    assign mode_out = mode_out_reg;
    assign host_port_en = (mode_out_reg != CFSD_MODE_HW);
    assign line_code = line_code_reg;
    assign bus_style = bus_style_reg;
    assign jitter_pos = jitter_pos_reg;
    assign host_access_en = access_en_reg;
    assign host_access_start = access_start_reg;

    // Checks on the decode, sampled on the one clock
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    mode_ser_a: assert property (op_mode_mid |=> ##1 mode_out_reg == CFSD_MODE_SER)
        else $error("mid strap did not give serial host mode");
    mode_hw_a: assert property (!op_mode_mid && !op_mode_high |=> ##1 !host_port_en)
        else $error("low strap left host port open");
    code_bipolar_a: assert property (mif.hw && !unipolar_reg |=> line_code_reg == CFSD_LC_AMI)
        else $error("bipolar hardware mode used a zero-substitution coder");
    code_zs_a: assert property (mif.hw && unipolar_reg && !code_pin_reg && e1_reg
        |=> line_code_reg == CFSD_LC_HDB3)
        else $error("low code pin at E1 did not select HDB3");
    code_ami_a: assert property (mif.hw && unipolar_reg && code_pin_reg
        |=> line_code_reg == CFSD_LC_AMI)
        else $error("high code pin did not select AMI");
    code_sw_a: assert property (mif.host && !sw_code_reg && !e1_reg
        |=> line_code_reg == CFSD_LC_B8ZS)
        else $error("software bit did not select B8ZS at T1");
    bus_split_a: assert property (mif.host && code_pin_reg |=> bus_style_reg == CFSD_BUS_SPLIT)
        else $error("high style pin did not select split strobes");
    bus_dsrw_a: assert property (mif.host && !code_pin_reg |=> bus_style_reg == CFSD_BUS_DSRW)
        else $error("low style pin did not select strobe plus direction");
    access_gate_a: assert property (host_access_en |-> $past(!cs_n_reg) && $past(mif.host))
        else $error("host access enabled without chip select low");
    access_edge_a: assert property (host_access_start |-> host_access_en && $past(cs_prev_reg))
        else $error("access start without a falling chip select");
    jit_path_a: assert property (mif.hw && !jit_float_reg
        |=> jitter_pos_reg == ($past(cs_n_reg) ? CFSD_JIT_RX : CFSD_JIT_TX))
        else $error("jitter position does not follow its pin");
    jit_off_a: assert property (mif.hw && jit_float_reg
        |=> jitter_pos_reg == CFSD_JIT_OFF)
        else $error("floating jitter pin did not disable attenuator");
    // Low code pin at T1 is the other zero-substitution choice
    code_t1_a: assert property (mif.hw && unipolar_reg && !code_pin_reg && !e1_reg
        |=> line_code_reg == CFSD_LC_B8ZS)
        else $error("low code pin at T1 did not select B8ZS");
    // Software bit set means transparent coding whatever the pin says
    code_sw_ami_a: assert property (mif.host && sw_code_reg
        |=> line_code_reg == CFSD_LC_AMI)
        else $error("software bit did not select AMI");
    code_sw_e1_a: assert property (mif.host && !sw_code_reg && e1_reg
        |=> line_code_reg == CFSD_LC_HDB3)
        else $error("software bit did not select HDB3 at E1");
    // Host mode takes the jitter position from software, never the pin
    jit_host_a: assert property (mif.host |=> jitter_pos_reg == $past(sw_jit_reg))
        else $error("host mode jitter position not taken from software");
    pin_route_a: assert property (mif.hw |=> !host_access_en && bus_style_reg == CFSD_BUS_SPLIT)
        else $error("chip select meaning leaked into hardware mode");

    ser_access_c: cover property (mode_out_reg == CFSD_MODE_SER && host_access_start);
    par_hdb3_c: cover property (mode_out_reg == CFSD_MODE_PAR && line_code_reg == CFSD_LC_HDB3);
    hw_jit_off_c: cover property (mode_out_reg == CFSD_MODE_HW && jitter_pos_reg == CFSD_JIT_OFF);
    hw_b8zs_c: cover property (mode_out_reg == CFSD_MODE_HW && line_code_reg == CFSD_LC_B8ZS);
endmodule

// *** verification/cfsd_far_end.sv ***
// Behavioural strap wiring and host microcontroller facing the strap decoder
`timescale 1ns/100ps
module cfsd_far_end (
    input wire logic ref_clk,
    input wire logic host_sel,
    input wire logic jitter_level,
    input wire logic go,
    input wire logic [3:0] len,
    output logic cs_jitter_pin,
    output logic busy
);
    logic cs_n_reg = 1'b1; // Host chip select, idle high
    logic [4:0] cnt_reg = 5'h0; // Access cycles still to run
    // Host owns the shared pin in host mode, the board strap otherwise
    assign cs_jitter_pin = host_sel ? cs_n_reg : jitter_level;
    assign busy = (cnt_reg != 5'h0);
    // Fresh fall per access of nonzero len: low for len cycles, then one idle-high cycle
    // so two such accesses never share one assertion; len 0 leaves the select low
    always @(posedge ref_clk) begin
        if (cnt_reg == 5'h0) begin
            if (go) begin
                cs_n_reg <= 1'b0;
                cnt_reg <= {1'b0, len} + 5'h1;
            end
        end else begin
            cnt_reg <= cnt_reg - 5'h1;
            if (cnt_reg == 5'h2) begin
                cs_n_reg <= 1'b1;
            end
        end
    end
endmodule

// *** verification/config_strap_decode_bench.sv ***
// Self-checking bench for the configuration strap decoder
`timescale 1ns/100ps
module config_strap_decode_bench;
    import cfsd_pkg::*;
    // One decode case: strap inputs, then the outputs they should give
    typedef struct {
        logic hi, mid, cp, jl, fl, uni, e1, sw;
        cfsd_jit_t sj;
        cfsd_mode_t m;
        cfsd_code_t lc;
        cfsd_bus_t bs;
        cfsd_jit_t jp;
    } cfsd_row_t;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic hi = 1'b0, mid = 1'b0, cp = 1'b0, jl = 1'b0, fl = 1'b0;
    logic uni = 1'b0, e1 = 1'b0, sw = 1'b0, go = 1'b0;
    logic [3:0] len = 4'h4;
    cfsd_jit_t sj = CFSD_JIT_OFF;
    logic pin, busy, port_en, acc_en, acc_start;
    cfsd_mode_t mode;
    cfsd_code_t lc;
    cfsd_bus_t bs;
    cfsd_jit_t jp;
    int mismatches = 0;
    int checks = 0;
    int starts = 0; // Access start pulses seen
    int en_cyc = 0; // Cycles with access enabled
    int s0, e0;
    // Hardware rows first, then parallel and serial host rows
    cfsd_row_t rows [7] = '{
        '{0,0,0,0,0,1,1,0,CFSD_JIT_TX,CFSD_MODE_HW,CFSD_LC_HDB3,CFSD_BUS_SPLIT,CFSD_JIT_TX},
        '{0,0,0,1,0,1,0,1,CFSD_JIT_OFF,CFSD_MODE_HW,CFSD_LC_B8ZS,CFSD_BUS_SPLIT,CFSD_JIT_RX},
        '{0,0,1,0,1,1,0,0,CFSD_JIT_TX,CFSD_MODE_HW,CFSD_LC_AMI,CFSD_BUS_SPLIT,CFSD_JIT_OFF},
        '{0,0,0,1,0,0,1,0,CFSD_JIT_TX,CFSD_MODE_HW,CFSD_LC_AMI,CFSD_BUS_SPLIT,CFSD_JIT_RX},
        '{1,0,1,0,1,1,1,0,CFSD_JIT_RX,CFSD_MODE_PAR,CFSD_LC_HDB3,CFSD_BUS_SPLIT,CFSD_JIT_RX},
        '{1,1,0,1,0,1,1,1,CFSD_JIT_TX,CFSD_MODE_SER,CFSD_LC_AMI,CFSD_BUS_DSRW,CFSD_JIT_TX},
        '{1,0,0,0,0,1,0,0,CFSD_JIT_OFF,CFSD_MODE_PAR,CFSD_LC_B8ZS,CFSD_BUS_DSRW,CFSD_JIT_OFF}
    };
    // Free-running 250 MHz clock
    always #2 ref_clk = ~ref_clk;
    // Far side: straps plus host chip-select engine
    cfsd_far_end i_far (
        .ref_clk(ref_clk), .host_sel(hi | mid), .jitter_level(jl), .go(go), .len(len),
        .cs_jitter_pin(pin), .busy(busy)
    );
    cfsd_top i_dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .op_mode_high(hi), .op_mode_mid(mid),
        .code_style_pin(cp), .cs_jitter_pin(pin), .cs_jitter_float(fl),
        .unipolar_mode(uni), .e1_rate(e1), .sw_line_code_bit(sw), .sw_jitter_pos(sj),
        .mode_out(mode), .host_port_en(port_en), .line_code(lc), .bus_style(bs),
        .jitter_pos(jp), .host_access_en(acc_en), .host_access_start(acc_start)
    );
    // Tally access pulses and enabled cycles for the access tests
    always @(posedge ref_clk) begin
        if (acc_start === 1'b1) starts = starts + 1;
        if (acc_en === 1'b1) en_cyc = en_cyc + 1;
    end
    // Decoded selections
    task cmp3(input logic [2:0] got, input logic [2:0] exp);
        checks = checks + 1;
        if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("BAD %0t select got %b want %b", $time, got, exp);
        end
    endtask
    // Single flags
    task cmp1(input logic got, input logic exp);
        checks = checks + 1;
        if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("BAD %0t flag got %b want %b", $time, got, exp);
        end
    endtask
    // Event counts from the tally above
    task cmp_n(input int got, input int exp);
        checks = checks + 1;
        if (got != exp) begin
            mismatches = mismatches + 1;
            $display("BAD %0t count got %0d want %0d", $time, got, exp);
        end
    endtask
    // One host access of n low cycles; bounded wait so a stuck engine cannot hang
    task access(input logic [3:0] n);
        int k;
        @(posedge ref_clk);
        go <= 1'b1;
        len <= n;
        @(posedge ref_clk);
        go <= 1'b0;
        k = 0;
        do begin
            @(posedge ref_clk);
            #1;
            k = k + 1;
        end while (busy === 1'b1 && k < 40);
        if (k >= 40) begin
            mismatches = mismatches + 1;
            $display("BAD %0t access did not finish", $time);
        end
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Watchdog, far beyond the hundred or so cycles the tests need
    initial begin
        #(4 * 3000);
        mismatches = mismatches + 1;
        $display("BAD %0t watchdog expired", $time);
        summarize;
    end
    // Main sequence
    initial begin
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        // Table of static strap cases, outputs two edges after the inputs change
        foreach (rows[i]) begin
            @(posedge ref_clk);
            hi <= rows[i].hi; mid <= rows[i].mid; cp <= rows[i].cp; jl <= rows[i].jl;
            fl <= rows[i].fl; uni <= rows[i].uni; e1 <= rows[i].e1; sw <= rows[i].sw;
            sj <= rows[i].sj;
            repeat (3) @(posedge ref_clk);
            #1;
            cmp3(mode, rows[i].m);
            cmp3(lc, rows[i].lc);
            cmp3({1'b0, bs}, {1'b0, rows[i].bs});
            cmp3(jp, rows[i].jp);
            cmp1(port_en, rows[i].m != CFSD_MODE_HW);
            cmp1(acc_en, 1'b0);
        end
        // Single access in parallel host mode
        s0 = starts;
        e0 = en_cyc;
        access(4'h4);
        repeat (3) @(posedge ref_clk);
        cmp_n(starts - s0, 1);
        cmp_n(en_cyc - e0, 4);
        // Back-to-back shortest accesses, three idle-high cycles apart
        s0 = starts;
        e0 = en_cyc;
        access(4'h1);
        access(4'h1);
        repeat (3) @(posedge ref_clk);
        cmp_n(starts - s0, 2);
        cmp_n(en_cyc - e0, 2);
        // Two-cycle access with the mode strap at mid: serial host port
        @(posedge ref_clk);
        mid <= 1'b1;
        repeat (4) @(posedge ref_clk);
        s0 = starts;
        e0 = en_cyc;
        access(4'h2);
        repeat (3) @(posedge ref_clk);
        #1;
        cmp3(mode, CFSD_MODE_SER);
        cmp_n(starts - s0, 1);
        cmp_n(en_cyc - e0, 2);
        // Hardware mode: shared pin low is a jitter strap, not a select
        @(posedge ref_clk);
        hi <= 1'b0;
        mid <= 1'b0;
        jl <= 1'b1;
        repeat (4) @(posedge ref_clk);
        jl <= 1'b0;
        s0 = starts;
        e0 = en_cyc;
        repeat (6) @(posedge ref_clk);
        cmp_n(starts - s0, 0);
        cmp_n(en_cyc - e0, 0);
        // Reset in mid-run from parallel host mode
        hi <= 1'b1;
        repeat (4) @(posedge ref_clk);
        // Host opens an access during reset; select still low at release
        rst_n <= 1'b0;
        go <= 1'b1;
        len <= 4'hf;
        s0 = starts;
        e0 = en_cyc;
        @(posedge ref_clk);
        go <= 1'b0;
        #1;
        cmp3(mode, CFSD_MODE_HW);
        cmp3(jp, CFSD_JIT_OFF);
        cmp3(lc, CFSD_LC_AMI);
        cmp3({1'b0, bs}, {1'b0, CFSD_BUS_SPLIT});
        cmp1(port_en, 1'b0);
        cmp1(acc_en, 1'b0);
        cmp1(acc_start, 1'b0);
        @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        cmp3(mode, CFSD_MODE_PAR);
        // Select already low at release: one start, enabled while it stays low
        repeat (16) @(posedge ref_clk);
        cmp_n(starts - s0, 1);
        cmp_n(en_cyc - e0, 14);
        summarize;
    end
endmodule
